// ### rtl/mmd_pkg.sv
// mmd_pkg: constants and types for the memory map decode block.
// assumes one 10 MHz core clock and a byte-wide register port.
package mmd_pkg;
  // register port offsets
  localparam logic [7:0] REG_PTR_LO = 8'h82;
  localparam logic [7:0] REG_PTR_HI = 8'h83;
  localparam logic [7:0] REG_AUX = 8'h8e;
  localparam logic [7:0] REG_AUX1 = 8'ha2;
  localparam logic [7:0] REG_FLASH_CFG = 8'hb1;
  // field positions
  localparam int MAP_B0 = 0;
  localparam int MAP_B1 = 1;
  localparam int OFFCHIP_B = 1;
  localparam int PSEL_B = 0;
  // address map
  localparam logic [15:0] LOW8K_TOP = 16'h1fff;
  localparam logic [15:0] HI_BLK_BASE = 16'he000;
  localparam logic [15:0] ONCHIP_XDATA_RAM_TOP = 16'h02ff;
  localparam int ONCHIP_XDATA_RAM_BYTES = 768;
  localparam int ONCHIP_XDATA_RAM_AW = 10;
  localparam logic [7:0] IRAM_UPPER = 8'h80;
  localparam logic [1:0] MAP_OVERLAY = 2'b00;
  localparam logic [1:0] MAP_BOTH = 2'b01;
  // strobe length of an off-chip cycle, in clocks
  localparam logic [3:0] STROBE_CYC = 4'h3;
  localparam logic [3:0] CNT_ONE = 4'h1;
  typedef enum logic [1:0] {RK_POR, RK_WDT, RK_BOD, RK_SWR} mmd_rst_kind_type;
endpackage : mmd_pkg

// ### rtl/mmd_fetch_if.sv
// mmd_fetch_if: program counter and block map to the fetch mapper.
// assumes both ends run on the core clock.
`timescale 1ns/1ns
`default_nettype none
interface mmd_fetch_if;
  logic [15:0] pc;
  logic [1:0] map;
  logic sec_sel;
  logic [15:0] blk_addr;
  modport mapper (input pc, input map, output sec_sel, output blk_addr);
  modport core (output pc, output map, input sec_sel, input blk_addr);
endinterface : mmd_fetch_if
`default_nettype wire

// ### rtl/mmd_fetch_map.sv
// mmd_fetch_map: picks primary or secondary program block per fetch.
// assumes pc and map are stable core-clock signals; result lags one clock.
`timescale 1ns/1ns
`default_nettype none
module mmd_fetch_map
  import mmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  mmd_fetch_if.mapper fif
);
  logic sec_r;
  logic sec_nxt;
  logic [15:0] addr_r;
  logic [15:0] addr_nxt;

  always_comb
  begin
    sec_nxt = 1'b0;
    // RL7 overlay fetch select
    if (fif.map == MAP_OVERLAY)
      sec_nxt = (fif.pc <= LOW8K_TOP);
    else if (fif.map == MAP_BOTH)
      sec_nxt = (fif.pc >= HI_BLK_BASE);
    // offset inside the secondary block is the low 8K
    addr_nxt = sec_nxt ? (fif.pc & LOW8K_TOP) : fif.pc;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sec_r <= 1'b0;
      addr_r <= 16'h0000;
    end
    else
    begin
      sec_r <= sec_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign fif.sec_sel = sec_r;
  assign fif.blk_addr = addr_r;

  default clocking cb @(posedge clk_sys);
  endclocking

  overlay_fetch_a: assert property (disable iff (rst) // RL7
    fif.map == MAP_OVERLAY |=> sec_r == ($past(fif.pc) <= LOW8K_TOP))
    else $error("overlay fetch block wrong");
endmodule : mmd_fetch_map
`default_nettype wire

// ### rtl/mmd_memory_map_decode.sv
// mmd_memory_map_decode: program block map, data space decode,
// external-move routing and dual data pointers of the core.
// assumes the cpu drives one-cycle requests and the register port;
// off-chip data memory sits on the multiplexed port 0 / port 2 bus.
//
// How it works
// RL1 - power-on reset loads map from start-up bits
// RL2 - watchdog, brown-out, software reset map cases
// RL3 - unknown map bit1 keeps its old value
// RL4 - start-up bit low means programmed
// RL5 - software rewrites map bit0, start-up untouched
// RL6 - software avoids switching while in low 8K
// RL7 - map 00 fetches low 8K from secondary
// RL8 - 1024 bytes internal ram, 64KB external space
// RL9 - 00h-7fh reachable direct and indirect
// RL10 - upper 80h-ffh: indirect ram, direct registers
// RL11 - selector clear: 000h-2ffh on chip, pins quiet
// RL12 - selector clear: pointer 0300h+ runs bus cycle
// RL13 - selector clear: 8-bit move on chip 0-ffh
// RL14 - selector set: every move strobes the bus
// RL15 - pointer move: high byte port2, low port0
// RL16 - stack stays in 256-byte internal ram
// RL17 - two pointers chosen by select bit
// RL18 - select bit is aux1 bit0, increment toggles
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module mmd_memory_map_decode
  import mmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire mmd_pkg::mmd_rst_kind_type rst_kind,
  input wire logic startup_map_bit0,
  input wire logic startup_map_bit1,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] fetch_pc,
  output logic fetch_secondary,
  output logic [15:0] fetch_block_addr,
  input wire logic iram_req,
  input wire logic [7:0] iram_addr,
  input wire logic iram_indirect,
  input wire logic iram_stack,
  output logic iram_lower_hit,
  output logic iram_upper_hit,
  output logic sfr_hit,
  input wire logic xmov_req,
  input wire logic xmov_write,
  input wire logic xmov_use_ptr,
  input wire logic [7:0] xmov_ri_addr,
  input wire logic [7:0] xmov_wdata,
  output logic [7:0] xmov_rdata,
  output logic xmov_done,
  output logic xmov_busy,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic p0_oe_n,
  output logic [7:0] p2_out,
  output logic p2_oe_n,
  output logic ale,
  output logic rd_n,
  output logic wr_n
);
  typedef enum {XS_IDLE, XS_ADDR, XS_STROBE, XS_DONE} mmd_xstate_type;

  // RL4 programmed reads as logic 0
  function automatic logic [1:0] mmd_reset_map(input mmd_rst_kind_type k,
    input logic sc1, input logic sc0, input logic old_b1);
    logic [1:0] m;
    m = {~sc1, ~sc0};
    if (k == RK_SWR)
      m = {1'b1, ~sc0};
    else if (k == RK_WDT || k == RK_BOD)
      m = {(~sc1) | old_b1, ~sc0};
    return m;
  endfunction : mmd_reset_map

  // start-up bits come from pins; the first stage is read by nothing else
  logic [1:0] sc_m_r;
  logic [1:0] sc_q_r;
  logic [7:0] p0_m_r;
  logic [7:0] p0_q_r;

  logic [1:0] map_r, map_nxt;
  logic offchip_r, offchip_nxt;
  logic psel_r, psel_nxt;
  logic [15:0] dp0_r, dp0_nxt, dp1_r, dp1_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic lower_r, lower_nxt, upper_r, upper_nxt, sfr_r, sfr_nxt;
  mmd_xstate_type xs_r, xs_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [15:0] xa_r, xa_nxt;
  logic [7:0] xd_r, xd_nxt, xrd_r, xrd_nxt;
  logic xw_r, xw_nxt, xp_r, xp_nxt, done_r, done_nxt;
  logic ale_r, ale_nxt, rdn_r, rdn_nxt, wrn_r, wrn_nxt;
  logic [7:0] p0o_r, p0o_nxt;
  logic p0oen_r, p0oen_nxt, p2oen_r, p2oen_nxt;
  logic onchip_xdata_ram_rd_r, onchip_xdata_ram_rd_nxt;

  // RL8 on-chip expanded ram, 768 of the 1024 internal bytes
  logic [7:0] onchip_xdata_ram_mem [ONCHIP_XDATA_RAM_BYTES];
  logic [ONCHIP_XDATA_RAM_AW-1:0] onchip_xdata_ram_a_r;

  logic [15:0] dptr_sel;
  logic [15:0] xaddr;
  logic onchip;
  logic start;

  // RL17 pointer chosen by select bit
  assign dptr_sel = psel_r ? dp1_r : dp0_r;
  assign xaddr = xmov_use_ptr ? dptr_sel : {8'h00, xmov_ri_addr};
  // RL11 RL13 on-chip when selector clear; 8-bit form stays below 100h
  assign onchip = !offchip_r && (!xmov_use_ptr || xaddr <= ONCHIP_XDATA_RAM_TOP);
  assign start = xmov_req && xs_r == XS_IDLE;

  always_comb
  begin
    map_nxt = map_r;
    offchip_nxt = offchip_r;
    psel_nxt = psel_r;
    dp0_nxt = dp0_r;
    dp1_nxt = dp1_r;
    rdata_nxt = 8'h00;
    if (rst)
    begin
      // RL1 RL2 RL3 reset kind picks map
      map_nxt = mmd_reset_map(rst_kind, sc_q_r[1], sc_q_r[0], map_r[MAP_B1]);
      offchip_nxt = 1'b0;
      psel_nxt = 1'b0;
      dp0_nxt = 16'h0000;
      dp1_nxt = 16'h0000;
    end
    else if (reg_we)
    begin
      case (reg_addr)
        // RL5 only map bit0 is writable
        REG_FLASH_CFG: map_nxt[MAP_B0] = reg_wdata[MAP_B0];
        REG_AUX: offchip_nxt = reg_wdata[OFFCHIP_B];
        // RL18 bit0 so an increment toggles it
        REG_AUX1: psel_nxt = reg_wdata[PSEL_B];
        REG_PTR_LO:
          if (psel_r)
            dp1_nxt[7:0] = reg_wdata;
          else
            dp0_nxt[7:0] = reg_wdata;
        REG_PTR_HI:
          if (psel_r)
            dp1_nxt[15:8] = reg_wdata;
          else
            dp0_nxt[15:8] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_re)
    begin
      case (reg_addr)
        REG_FLASH_CFG: rdata_nxt = {6'h00, map_r};
        REG_AUX: rdata_nxt = {6'h00, offchip_r, 1'b0};
        REG_AUX1: rdata_nxt = {7'h00, psel_r};
        REG_PTR_LO: rdata_nxt = dptr_sel[7:0];
        REG_PTR_HI: rdata_nxt = dptr_sel[15:8];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_comb
  begin
    lower_nxt = 1'b0;
    upper_nxt = 1'b0;
    sfr_nxt = 1'b0;
    if (iram_req)
    begin
      // RL9 RL10 RL16 stack always goes to ram
      if (iram_addr < IRAM_UPPER)
        lower_nxt = 1'b1;
      else if (iram_indirect || iram_stack)
        upper_nxt = 1'b1;
      else
        sfr_nxt = 1'b1;
    end
  end

  always_comb
  begin
    xs_nxt = xs_r;
    cnt_nxt = cnt_r;
    xa_nxt = xa_r;
    xd_nxt = xd_r;
    xw_nxt = xw_r;
    xp_nxt = xp_r;
    xrd_nxt = xrd_r;
    done_nxt = 1'b0;
    onchip_xdata_ram_rd_nxt = 1'b0;
    if (onchip_xdata_ram_rd_r)
      xrd_nxt = onchip_xdata_ram_mem[onchip_xdata_ram_a_r];
    case (xs_r)
      XS_IDLE:
        if (start)
        begin
          xa_nxt = xaddr;
          xd_nxt = xmov_wdata;
          xw_nxt = xmov_write;
          xp_nxt = xmov_use_ptr;
          if (onchip)
          begin
            onchip_xdata_ram_rd_nxt = !xmov_write;
            done_nxt = 1'b1;
          end
          else
            // RL12 RL14 off-chip bus cycle
            xs_nxt = XS_ADDR;
        end
      XS_ADDR:
      begin
        xs_nxt = XS_STROBE;
        cnt_nxt = STROBE_CYC;
      end
      XS_STROBE:
      begin
        cnt_nxt = cnt_r - CNT_ONE;
        if (cnt_r == CNT_ONE)
        begin
          xs_nxt = XS_DONE;
          if (!xw_r)
            xrd_nxt = p0_q_r;
        end
      end
      XS_DONE:
      begin
        xs_nxt = XS_IDLE;
        done_nxt = 1'b1;
      end
      default: xs_nxt = XS_IDLE;
    endcase
    // pin values follow the state being entered
    ale_nxt = (xs_nxt == XS_ADDR);
    rdn_nxt = !(xs_nxt == XS_STROBE && !xw_nxt);
    wrn_nxt = !(xs_nxt == XS_STROBE && xw_nxt);
    p0o_nxt = (xs_nxt == XS_STROBE) ? xd_nxt : xa_nxt[7:0];
    p0oen_nxt = !(xs_nxt == XS_ADDR || (xs_nxt == XS_STROBE && xw_nxt));
    // RL15 high byte held on port 2 for pointer form
    p2oen_nxt = !((xs_nxt == XS_ADDR || xs_nxt == XS_STROBE) && xp_nxt);
  end

  always_ff @(posedge clk_sys)
  begin
    sc_m_r <= {startup_map_bit1, startup_map_bit0};
    sc_q_r <= sc_m_r;
    p0_m_r <= p0_in;
    p0_q_r <= p0_m_r;
    map_r <= map_nxt;
    if (start && onchip)
      onchip_xdata_ram_a_r <= xaddr[ONCHIP_XDATA_RAM_AW-1:0];
    if (rst)
    begin
      offchip_r <= 1'b0;
      psel_r <= 1'b0;
      dp0_r <= 16'h0000;
      dp1_r <= 16'h0000;
      rdata_r <= 8'h00;
      {lower_r, upper_r, sfr_r} <= 3'b000;
      xs_r <= XS_IDLE;
      cnt_r <= 4'h0;
      xa_r <= 16'h0000;
      {xd_r, xrd_r, p0o_r} <= 24'h000000;
      {xw_r, xp_r, done_r, onchip_xdata_ram_rd_r, ale_r} <= 5'h00;
      {rdn_r, wrn_r, p0oen_r, p2oen_r} <= 4'hf;
    end
    else
    begin
      offchip_r <= offchip_nxt;
      psel_r <= psel_nxt;
      dp0_r <= dp0_nxt;
      dp1_r <= dp1_nxt;
      rdata_r <= rdata_nxt;
      {lower_r, upper_r, sfr_r} <= {lower_nxt, upper_nxt, sfr_nxt};
      xs_r <= xs_nxt;
      cnt_r <= cnt_nxt;
      xa_r <= xa_nxt;
      {xd_r, xrd_r, p0o_r} <= {xd_nxt, xrd_nxt, p0o_nxt};
      {xw_r, xp_r, done_r, onchip_xdata_ram_rd_r, ale_r} <=
        {xw_nxt, xp_nxt, done_nxt, onchip_xdata_ram_rd_nxt, ale_nxt};
      {rdn_r, wrn_r, p0oen_r, p2oen_r} <= {rdn_nxt, wrn_nxt, p0oen_nxt, p2oen_nxt};
    end
  end

  // write port of the expanded ram; no bus pins move
  always_ff @(posedge clk_sys)
  begin
    if (!rst && start && onchip && xmov_write)
      onchip_xdata_ram_mem[xaddr[ONCHIP_XDATA_RAM_AW-1:0]] <= xmov_wdata;
  end

  mmd_fetch_if fif ();
  assign fif.pc = fetch_pc;
  assign fif.map = map_r;
  mmd_fetch_map u_fetch (
    .clk_sys(clk_sys),
    .rst(rst),
    .fif(fif)
  );

  assign fetch_secondary = fif.sec_sel;
  assign fetch_block_addr = fif.blk_addr;
  assign reg_rdata = rdata_r;
  assign iram_lower_hit = lower_r;
  assign iram_upper_hit = upper_r;
  assign sfr_hit = sfr_r;
  // read data: on-chip reads appear one clock after xmov_done
  assign xmov_rdata = xrd_r;
  assign xmov_done = done_r;
  assign xmov_busy = (xs_r != XS_IDLE);
  assign p0_out = p0o_r;
  assign p0_oe_n = p0oen_r;
  assign p2_out = xa_r[15:8];
  assign p2_oe_n = p2oen_r;
  assign ale = ale_r;
  assign rd_n = rdn_r;
  assign wr_n = wrn_r;

  default clocking cb @(posedge clk_sys);
  endclocking

  sequence s_ext_start;
    start && !onchip;
  endsequence
  sequence s_on_start;
    start && onchip;
  endsequence

  por_map_load_a: assert property ( // RL1
    rst && rst_kind == RK_POR |=> map_r == ~$past(sc_q_r))
    else $error("map not loaded from start-up bits");
  wdt_map_keep_a: assert property ( // RL3
    rst && (rst_kind == RK_WDT || rst_kind == RK_BOD) && sc_q_r[1]
    |=> map_r[1] == $past(map_r[1]) && map_r[0] == !$past(sc_q_r[0]))
    else $error("watchdog reset map wrong");
  swr_map_a: assert property ( // RL2
    rst && rst_kind == RK_SWR |=> map_r == {1'b1, !$past(sc_q_r[0])})
    else $error("software reset map wrong");
  map_bit1_ro_a: assert property (disable iff (rst) // RL5
    !$past(rst) |-> $stable(map_r[1]))
    else $error("map bit1 changed by software");
  onchip_quiet_a: assert property (disable iff (rst) // RL11
    s_on_start |=> (rd_n && wr_n && !ale && p0_oe_n && xmov_done))
    else $error("on-chip move touched the bus");
  bus_cycle_a: assert property (disable iff (rst) // RL14
    s_ext_start |=> ale ##1 (!rd_n || !wr_n)[*3] ##1 (rd_n && wr_n) ##1 xmov_done)
    else $error("off-chip cycle malformed");
  ptr_high_a: assert property (disable iff (rst) // RL15
    (s_ext_start and xmov_use_ptr) |=> !p2_oe_n && p2_out == $past(dptr_sel[15:8]))
    else $error("pointer high byte missing");
  upper_split_a: assert property (disable iff (rst) // RL10
    iram_req && iram_addr >= IRAM_UPPER
    |=> (sfr_hit == !($past(iram_indirect) || $past(iram_stack))) && (upper_r != sfr_hit))
    else $error("upper ram and registers mixed");
  ptr_isolate_a: assert property (disable iff (rst) // RL17
    reg_we && reg_addr == REG_PTR_LO && !psel_r |=> $stable(dp1_r))
    else $error("wrong data pointer written");
endmodule : mmd_memory_map_decode
`default_nettype wire

// ### verification/mmd_xmem_model.sv
// mmd_xmem_model: off-chip data memory on the multiplexed port bus.
// assumes ale, rd_n and wr_n come registered from the block on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module mmd_xmem_model
(
  input wire logic clk_sys,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] p0_out,
  input wire logic p0_oe_n,
  input wire logic [7:0] p2_out,
  input wire logic p2_oe_n,
  output logic [7:0] p0_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_r = 16'h0000;
  logic [7:0] idle_r = 8'h5a;
  always @(posedge clk_sys)
  begin
    if (ale)
      addr_r <= {(p2_oe_n ? 8'h00 : p2_out), p0_out};
    if (!wr_n && !p0_oe_n)
      mem[addr_r] <= p0_out;
    idle_r <= ~idle_r;
  end
  // drive only under read strobe
  // a released bus toggles so stale data never looks valid
  assign p0_in = (!rd_n && p0_oe_n) ? mem[addr_r] : idle_r;
endmodule : mmd_xmem_model
`default_nettype wire

// ### verification/tb.sv
// tb: self-checking bench for the memory map decode block.
// assumes a 10 MHz core clock and the register offsets of mmd_pkg.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import mmd_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1;
  mmd_rst_kind_type rst_kind = RK_POR;
  logic startup_map_bit0 = 1'b1, startup_map_bit1 = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_we = 1'b0, reg_re = 1'b0;
  logic [15:0] fetch_pc = 16'h0000, fetch_block_addr;
  logic fetch_secondary, iram_lower_hit, iram_upper_hit, sfr_hit;
  logic iram_req = 1'b0, iram_indirect = 1'b0, iram_stack = 1'b0;
  logic [7:0] iram_addr = 8'h00, xmov_ri_addr = 8'h00, xmov_wdata = 8'h00, xmov_rdata;
  logic xmov_req = 1'b0, xmov_write = 1'b0, xmov_use_ptr = 1'b0, xmov_done, xmov_busy;
  logic [7:0] p0_in, p0_out, p2_out;
  logic p0_oe_n, p2_oe_n, ale, rd_n, wr_n;
  int miscompares = 0, samples_checked = 0, cyc = 0;

  mmd_memory_map_decode i_mmd_memory_map_decode (.clk_sys(clk_sys), .rst(rst),
    .rst_kind(rst_kind), .startup_map_bit0(startup_map_bit0),
    .startup_map_bit1(startup_map_bit1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .fetch_pc(fetch_pc),
    .fetch_secondary(fetch_secondary), .fetch_block_addr(fetch_block_addr),
    .iram_req(iram_req), .iram_addr(iram_addr), .iram_indirect(iram_indirect),
    .iram_stack(iram_stack), .iram_lower_hit(iram_lower_hit),
    .iram_upper_hit(iram_upper_hit), .sfr_hit(sfr_hit), .xmov_req(xmov_req),
    .xmov_write(xmov_write), .xmov_use_ptr(xmov_use_ptr), .xmov_ri_addr(xmov_ri_addr),
    .xmov_wdata(xmov_wdata), .xmov_rdata(xmov_rdata), .xmov_done(xmov_done),
    .xmov_busy(xmov_busy), .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n),
    .p2_out(p2_out), .p2_oe_n(p2_oe_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));

  mmd_xmem_model i_mmd_xmem_model (.clk_sys(clk_sys), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p2_out(p2_out),
    .p2_oe_n(p2_oe_n), .p0_in(p0_in));

  always #50 clk_sys = ~clk_sys;

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // whole run is a few hundred cycles; a hang ends here
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_rd

  task automatic do_reset(input mmd_rst_kind_type k);
    @(posedge clk_sys);
    rst_kind <= k;
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  task automatic map_chk(input logic [1:0] exp);
    logic [7:0] d;
    reg_rd(REG_FLASH_CFG, d);
    check("block_map_field", {8'h00, d}, {14'h0000, exp});
  endtask : map_chk

  task automatic test_reset_map;
    logic [1:0] exp;
    exp = 2'b00;
    for (int k = 0; k < 4; k++)
    begin
      for (int s = 0; s < 4; s++)
      begin
        startup_map_bit1 <= s[1];
        startup_map_bit0 <= s[0];
        do_reset(mmd_rst_kind_type'(k));
        if (k == 0)
          exp = {~s[1], ~s[0]};
        else if (k == 3)
          exp = {1'b1, ~s[0]};
        else
          exp = {exp[1] | ~s[1], ~s[0]};
        map_chk(exp);
      end
    end
  endtask : test_reset_map

  task automatic fetch_all(input logic [1:0] m);
    logic [15:0] pcs [6];
    logic exp;
    pcs = '{16'h0000, 16'h1fff, 16'h2000, 16'hdfff, 16'he000, 16'hffff};
    foreach (pcs[i])
    begin
      exp = (m == 2'b00) ? (pcs[i] <= 16'h1fff) : (m == 2'b01) ? (pcs[i] >= 16'he000) : 1'b0;
      @(posedge clk_sys);
      fetch_pc <= pcs[i];
      @(posedge clk_sys);
      #1;
      check("fetch_secondary", {15'h0000, fetch_secondary}, {15'h0000, exp});
      check("fetch_block_addr", fetch_block_addr, exp ? (pcs[i] & 16'h1fff) : pcs[i]);
    end
  endtask : fetch_all

  task automatic test_fetch_map;
    do_reset(RK_POR);
    fetch_all(2'b00);
    reg_wr(REG_FLASH_CFG, 8'h03);
    map_chk(2'b01);
    fetch_all(2'b01);
    do_reset(RK_SWR);
    map_chk(2'b10);
    fetch_all(2'b10);
  endtask : test_fetch_map

  task automatic iram(input logic [7:0] a, input logic ind, input logic stk, input logic [2:0] e);
    @(posedge clk_sys);
    iram_req <= 1'b1;
    iram_addr <= a;
    iram_indirect <= ind;
    iram_stack <= stk;
    @(posedge clk_sys);
    iram_req <= 1'b0;
    #1;
    check("iram hits", {13'h0000, iram_lower_hit, iram_upper_hit, sfr_hit}, {13'h0000, e});
  endtask : iram

  task automatic test_iram;
    iram(8'h7f, 1'b0, 1'b0, 3'b100);
    iram(8'h7f, 1'b1, 1'b0, 3'b100);
    iram(8'h80, 1'b1, 1'b0, 3'b010);
    iram(8'h90, 1'b0, 1'b0, 3'b001);
    iram(8'hff, 1'b0, 1'b1, 3'b010);
  endtask : test_iram

  task automatic xmov(input logic wr, input logic ptr, input logic [7:0] ri,
    input logic [7:0] wd, input int exp_stb, input logic [15:0] exp_a, input logic [7:0] exp_rd);
    int n, stb, busy_pins;
    logic [15:0] seen_a;
    @(posedge clk_sys);
    xmov_req <= 1'b1;
    xmov_write <= wr;
    xmov_use_ptr <= ptr;
    xmov_ri_addr <= ri;
    xmov_wdata <= wd;
    @(posedge clk_sys);
    xmov_req <= 1'b0;
    n = 0;
    stb = 0;
    busy_pins = 0;
    seen_a = 16'h0000;
    #1;
    check("xmov_busy", {15'h0000, xmov_busy}, (exp_stb != 0) ? 16'h0001 : 16'h0000);
    while (xmov_done !== 1'b1 && n < 20)
    begin
      if (ale === 1'b1)
        seen_a = {(p2_oe_n === 1'b0) ? p2_out : 8'h00, p0_out};
      if (rd_n !== 1'b1 || wr_n !== 1'b1)
        stb++;
      if (ale !== 1'b0 || p0_oe_n !== 1'b1 || p2_oe_n !== 1'b1)
        busy_pins++;
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("xmov_done", {15'h0000, xmov_done}, 16'h0001);
    check("strobe cycles", 16'(stb), 16'(exp_stb));
    if (exp_stb == 0)
      check("port activity", 16'(busy_pins), 16'h0000);
    else
      check("bus address", seen_a, exp_a);
    @(posedge clk_sys);
    #1;
    if (!wr)
      check("xmov_rdata", {8'h00, xmov_rdata}, {8'h00, exp_rd});
  endtask : xmov

  task automatic toggle_psel;
    logic [7:0] d, d2;
    reg_rd(REG_AUX1, d);
    reg_wr(REG_AUX1, d + 8'h01);
    reg_rd(REG_AUX1, d2);
    check("pointer_select", {15'h0000, d2[0]}, {15'h0000, ~d[0]});
  endtask : toggle_psel

  task automatic test_xmov;
    logic [7:0] lo, hi;
    reg_wr(REG_AUX, 8'h00);
    reg_wr(REG_AUX1, 8'h00);
    reg_wr(REG_PTR_LO, 8'hff);
    reg_wr(REG_PTR_HI, 8'h02);
    xmov(1'b1, 1'b1, 8'h00, 8'h11, 0, 16'h0000, 8'h00);
    xmov(1'b0, 1'b1, 8'h00, 8'h00, 0, 16'h0000, 8'h11);
    toggle_psel();
    reg_wr(REG_PTR_LO, 8'h00);
    reg_wr(REG_PTR_HI, 8'h03);
    xmov(1'b1, 1'b1, 8'h00, 8'ha5, 3, 16'h0300, 8'h00);
    toggle_psel();
    reg_rd(REG_PTR_LO, lo);
    reg_rd(REG_PTR_HI, hi);
    check("data_pointer_zero", {hi, lo}, 16'h02ff);
    xmov(1'b1, 1'b0, 8'hff, 8'h22, 0, 16'h0000, 8'h00);
    xmov(1'b0, 1'b0, 8'hff, 8'h00, 0, 16'h0000, 8'h22);
    reg_wr(REG_AUX, 8'h02);
    xmov(1'b1, 1'b0, 8'h44, 8'h66, 3, 16'h0044, 8'h00);
    xmov(1'b1, 1'b1, 8'h00, 8'h77, 3, 16'h02ff, 8'h00);
    xmov(1'b0, 1'b1, 8'h00, 8'h00, 3, 16'h02ff, 8'h77);
    xmov(1'b0, 1'b0, 8'h44, 8'h00, 3, 16'h0044, 8'h66);
    toggle_psel();
    xmov(1'b0, 1'b1, 8'h00, 8'h00, 3, 16'h0300, 8'ha5);
  endtask : test_xmov

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset_map();
    test_fetch_map();
    test_iram();
    test_xmov();
    results();
  end
endmodule : tb
`default_nettype wire
